/* dv/tb.sv */
// Self-checking bench of the timer core: counter access, modes, capture unit.
// Assumes tcc_pkg is compiled first and the CPU partner model beside it.
`timescale 1ns/1ps
module tb;
	logic              clk, rst_n, ce, cpin, comp, csel, cap_ie, ovf_ie, cap_ack, ovf_ack, ext;
	logic [7:0]        ctla, ctlb, rdata, q;
	logic [4:0]        ptick;
	logic [15:0]       cnt, cap, w;
	logic              floor_o, ceil_o, ovf_f, cap_f, cap_irq, ovf_irq;
	tcc_pkg::tcc_cpu_t cpu;
	int                mismatches, check_count;

	// Design and CPU partner
	tcc_core uut (.clk(clk), .rst_n(rst_n), .ce(ce), .cpu(cpu), .timer_control_a(ctla),
		.timer_control_b(ctlb), .presc_tick(ptick), .ext_tick_pin(ext),
		.capture_input_pin(cpin), .comparator_output(comp), .capture_src_comp(csel),
		.capture_irq_enable(cap_ie), .overflow_irq_enable(ovf_ie), .capture_irq_ack(cap_ack),
		.overflow_irq_ack(ovf_ack), .rdata(rdata), .timer_count_value(cnt),
		.capture_value_reg(cap), .count_floor(floor_o), .count_ceiling(ceil_o),
		.count_overflow_flag(ovf_f), .capture_event_flag(cap_f), .capture_irq(cap_irq),
		.overflow_irq(ovf_irq));
	tcc_cpu_model cm (.clk(clk), .rdata(rdata), .cpu(cpu));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic tick(input logic [4:0] b, input int n);
		repeat (n) begin
			@(posedge clk) ptick <= b;
			@(posedge clk) ptick <= 5'h00;
		end
		#1;
	endtask

	// Mode field split over both control bytes, edge bit and tick source
	task automatic mode(input logic [3:0] m, input logic [2:0] cs, input logic e);
		@(posedge clk);
		ctla <= {6'h00, m[1:0]};
		ctlb <= {1'b0, e, 1'b0, m[3:2], cs};
	endtask

	task automatic do_reset;
		@(posedge clk) rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
	endtask

	task automatic ack(input logic c);
		@(posedge clk) begin
			cap_ack <= c;
			ovf_ack <= ~c;
		end
		@(posedge clk) begin
			cap_ack <= 1'b0;
			ovf_ack <= 1'b0;
		end
		cyc(2);
	endtask

	task automatic wait_cap;
		int i;
		i = 0;
		while (cap_f !== 1'b1) begin
			@(posedge clk);
			#1;
			i++;
			if (i > 20) begin
				mismatches++;
				finish_test();
			end
		end
	endtask

	task automatic s_reset;
		chk(cnt, 16'h0000);
		chk(cap, 16'h0000);
		chk({13'h0000, ovf_f, cap_f, floor_o}, 16'h0001);
		tick(5'h1f, 2);
		chk(cnt, 16'h0000);
	endtask

	task automatic s_rw;
		mode(4'h0, 3'h0, 1'b1);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'h01ff);
		chk(cnt, 16'h01ff);
		cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_CNT_LO, 8'h22, q);
		chk(cnt, 16'h0122);
		cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_CNT_HI, 8'hab, q);
		chk(cnt, 16'h0122);
		cm.acc(1'b1, 1'b0, tcc_pkg::TCC_SEL_CNT_HI, 8'h00, q);
		chk({8'h00, q}, 16'h00ab);
		cm.rd16(tcc_pkg::TCC_SEL_CNT_LO, w);
		chk(w, 16'h0122);
		mode(4'h0, 3'h1, 1'b1);
		fork
			cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_CNT_LO, 8'h55, q);
			tick(5'h01, 1);
		join
		chk(cnt, 16'h0155);
		tick(5'h01, 3);
		chk(cnt, 16'h0158);
	endtask

	task automatic s_count;
		@(posedge clk) ovf_ie <= 1'b1;
		mode(4'h0, 3'h2, 1'b1);
		tick(5'h01, 2);
		chk(cnt, 16'h0158);
		tick(5'h02, 2);
		chk(cnt, 16'h015a);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'hffff);
		tick(5'h02, 1);
		cyc(2);
		chk(cnt, 16'h0000);
		chk({13'h0000, floor_o, ovf_f, ovf_irq}, 16'h0007);
		ack(1'b0);
		chk(ovf_f, 1'b0);
		mode(4'h4, 3'h2, 1'b1);
		cm.wr16(tcc_pkg::TCC_SEL_CMP_LO, 16'h0010);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'h000f);
		tick(5'h02, 1);
		chk(cnt, 16'h0010);
		tick(5'h02, 1);
		chk(cnt, 16'h0000);
		mode(4'h0, 3'h7, 1'b1);
		@(posedge clk) ext <= 1'b1;
		cyc(6);
		chk(cnt, 16'h0001);
		@(posedge clk) ext <= 1'b0;
		cyc(6);
		chk(cnt, 16'h0001);
		mode(4'h0, 3'h6, 1'b1);
		@(posedge clk) ext <= 1'b1;
		cyc(6);
		chk(cnt, 16'h0001);
		@(posedge clk) ext <= 1'b0;
		cyc(6);
		chk(cnt, 16'h0002);
	endtask

	task automatic s_modes;
		logic [15:0] top;
		for (int k = 1; k <= 3; k++) begin
			top = (16'h0100 << (k - 1)) - 16'h0001;
			do_reset();
			mode(4'(k), 3'h1, 1'b1);
			cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, top - 16'h0001);
			tick(5'h01, 1);
			chk(cnt, top);
			cyc(1);
			chk(ceil_o, 1'b1);
			tick(5'h01, 1);
			chk(cnt, top - 16'h0001);
			mode(4'(k + 4), 3'h1, 1'b1);
			cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, top);
			tick(5'h01, 1);
			cyc(2);
			chk(cnt, 16'h0000);
			chk(ovf_f, 1'b1);
			cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_FLAGS, 8'h01, q);
			chk(ovf_f, 1'b0);
		end
	endtask

	task automatic s_capture;
		do_reset();
		@(posedge clk) cap_ie <= 1'b1;
		mode(4'h0, 3'h0, 1'b1);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'h1234);
		@(posedge clk) cpin <= 1'b1;
		wait_cap();
		chk(cap, 16'h1234);
		cyc(1);
		chk(cap_irq, 1'b1);
		ack(1'b1);
		chk(cap_f, 1'b0);
		cm.rd16(tcc_pkg::TCC_SEL_CAP_LO, w);
		chk(w, 16'h1234);
		cm.acc(1'b1, 1'b0, tcc_pkg::TCC_SEL_CNT_HI, 8'h00, q);
		chk({8'h00, q}, 16'h0012);
		mode(4'h0, 3'h0, 1'b0);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'h00aa);
		@(posedge clk) cpin <= 1'b0;
		wait_cap();
		chk(cap, 16'h00aa);
		cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_FLAGS, 8'h00, q);
		chk(cap_f, 1'b1);
		cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_FLAGS, 8'h20, q);
		chk(cap_f, 1'b0);
		@(posedge clk) cpin <= 1'b1;
		cyc(8);
		chk(cap_f, 1'b0);
		mode(4'h0, 3'h0, 1'b1);
		@(posedge clk) csel <= 1'b1;
		cyc(8);
		cm.acc(1'b0, 1'b1, tcc_pkg::TCC_SEL_FLAGS, 8'h20, q);
		cm.wr16(tcc_pkg::TCC_SEL_CNT_LO, 16'h0077);
		@(posedge clk) comp <= 1'b1;
		wait_cap();
		chk(cap, 16'h0077);
	endtask

	task automatic s_capwr;
		mode(4'h0, 3'h0, 1'b1);
		cm.wr16(tcc_pkg::TCC_SEL_CAP_LO, 16'h5678);
		chk(cap, 16'h0077);
		mode(4'he, 3'h0, 1'b1);
		cm.wr16(tcc_pkg::TCC_SEL_CAP_LO, 16'h5678);
		chk(cap, 16'h5678);
	endtask

	// Main sequence
	initial begin
		{rst_n, cpin, comp, csel, cap_ie, ovf_ie, cap_ack, ovf_ack, ext} = 9'h000;
		ce = 1'b1;
		ctla = 8'h00;
		ctlb = 8'h00;
		ptick = 5'h00;
		mismatches = 0;
		check_count = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		s_reset();
		s_rw();
		s_count();
		s_modes();
		s_capture();
		s_capwr();
		finish_test();
	end
endmodule

/* dv/tcc_cpu_model.sv */
// CPU-side partner: issues byte accesses and 16-bit pairs to the timer core.
// Assumes the caller runs off clk; every access is followed by one idle cycle.
`timescale 1ns/1ps
module tcc_cpu_model (
	input  wire logic         clk,
	input  wire logic [7:0]   rdata,
	output tcc_pkg::tcc_cpu_t cpu
);
	// Idle bus at time zero
	initial cpu = '{rd: 1'b0, wr: 1'b0, sel: tcc_pkg::TCC_SEL_NONE, wdata: 8'h00};

	// One access held from one edge to the taking edge, then released
	task automatic acc(input logic r, input logic w, input tcc_pkg::tcc_sel_t s,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		cpu <= '{rd: r, wr: w, sel: s, wdata: d};
		@(posedge clk);
		cpu <= '{rd: 1'b0, wr: 1'b0, sel: tcc_pkg::TCC_SEL_NONE, wdata: ~d};
		#1 q = rdata;
	endtask

	// High byte first, low byte second; callers keep the pair uninterrupted
	task automatic wr16(input tcc_pkg::tcc_sel_t lo, input logic [15:0] v);
		logic [7:0] t;
		acc(1'b0, 1'b1, tcc_pkg::tcc_sel_t'(lo + 3'h1), v[15:8], t);
		acc(1'b0, 1'b1, lo, v[7:0], t);
	endtask

	// Low byte first, then the high byte through the holding byte
	task automatic rd16(input tcc_pkg::tcc_sel_t lo, output logic [15:0] v);
		logic [7:0] l;
		logic [7:0] h;
		acc(1'b1, 1'b0, lo, 8'h00, l);
		acc(1'b1, 1'b0, tcc_pkg::tcc_sel_t'(lo + 3'h1), 8'h00, h);
		v = {h, l};
	endtask
endmodule

/* logic/tcc_core.sv */
// 16-bit timer core: counter, shared holding byte, capture unit.
// Assumes prescaler tick pulses on clk and one CPU byte access per cycle.
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_core (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire tcc_pkg::tcc_cpu_t cpu,
	input  wire logic [7:0]       timer_control_a,
	input  wire logic [7:0]       timer_control_b,
	input  wire logic [4:0]       presc_tick,
	input  wire logic             ext_tick_pin,
	input  wire logic             capture_input_pin,
	input  wire logic             comparator_output,
	input  wire logic             capture_src_comp,
	input  wire logic             capture_irq_enable,
	input  wire logic             overflow_irq_enable,
	input  wire logic             capture_irq_ack,
	input  wire logic             overflow_irq_ack,
	output logic [7:0]            rdata,
	output logic [15:0]           timer_count_value,
	output logic [15:0]           capture_value_reg,
	output logic                  count_floor,
	output logic                  count_ceiling,
	output logic                  count_overflow_flag,
	output logic                  capture_event_flag,
	output logic                  capture_irq,
	output logic                  overflow_irq
);
	logic [7:0]        hold_reg;
	logic [15:0]       compare_a_reg;
	tcc_pkg::tcc_dir_t dir_reg;
	tcc_pkg::tcc_dir_t dir_next;
	logic [15:0]       count_next;
	logic [3:0]        waveform_mode_field;
	logic [2:0]        tick_source_select;
	logic              timer_tick;
	logic              ext_rise;
	logic              ext_fall;
	logic              cap_rise;
	logic              cap_fall;
	logic              cap_event;
	logic [15:0]       top_val;
	logic              dual_slope;
	logic              ovf_at_top;
	logic              icr_is_top;
	logic              ovf_hit;
	logic              cnt_wr;
	logic              flag_wr;

	// Mode field from both control bytes
	assign waveform_mode_field = {timer_control_b[`TCC_CB_WGM_HI:`TCC_CB_WGM_LO],
		timer_control_a[`TCC_CA_WGM_LO:`TCC_CA_WGM_HI]}; // see [R13]
	assign tick_source_select = timer_control_b[`TCC_CB_CS_HI:`TCC_CB_CS_LO];
	assign cnt_wr  = cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_CNT_LO;
	assign flag_wr = cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_FLAGS;

	// External tick pin
	tcc_edge_det u_ext_edge (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.pin  (ext_tick_pin),
		.rise (ext_rise),
		.fall (ext_fall)
	);

	// Capture source, pin or comparator; switching may itself capture
	tcc_edge_det u_cap_edge (
		.clk  (clk),
		.rst_n(rst_n),
		.ce   (ce),
		.pin  (capture_src_comp ? comparator_output : capture_input_pin),
		.rise (cap_rise),
		.fall (cap_fall)
	);

	// Tick source select; zero gives no tick
	always_comb begin
		case (tick_source_select) // see [R10]
			`TCC_CS_STOP:     timer_tick = 1'b0;
			`TCC_CS_EXT_FALL: timer_tick = ext_fall;
			`TCC_CS_EXT_RISE: timer_tick = ext_rise;
			default:          timer_tick = presc_tick[tick_source_select - 3'h1];
		endcase
	end

	// Sequence shape per mode: ceiling, slope and overflow point
	always_comb begin
		top_val    = `TCC_COUNT_MAX;
		dual_slope = 1'b0;
		ovf_at_top = 1'b0;
		icr_is_top = 1'b0;
		case (waveform_mode_field) // see [R24]
			4'h1: begin
				top_val    = `TCC_TOP_8BIT;
				dual_slope = 1'b1;
			end
			4'h2: begin
				top_val    = `TCC_TOP_9BIT;
				dual_slope = 1'b1;
			end
			4'h3: begin
				top_val    = `TCC_TOP_10BIT;
				dual_slope = 1'b1;
			end
			4'h4: top_val = compare_a_reg;
			4'h5: begin
				top_val    = `TCC_TOP_8BIT;
				ovf_at_top = 1'b1;
			end
			4'h6: begin
				top_val    = `TCC_TOP_9BIT;
				ovf_at_top = 1'b1;
			end
			4'h7: begin
				top_val    = `TCC_TOP_10BIT;
				ovf_at_top = 1'b1;
			end
			4'h8, 4'hA: begin
				top_val    = capture_value_reg;
				dual_slope = 1'b1;
				icr_is_top = 1'b1;
			end
			4'h9, 4'hB: begin
				top_val    = compare_a_reg;
				dual_slope = 1'b1;
			end
			4'hC: begin
				top_val    = capture_value_reg;
				icr_is_top = 1'b1;
			end
			4'hE: begin
				top_val    = capture_value_reg;
				ovf_at_top = 1'b1;
				icr_is_top = 1'b1;
			end
			4'hF: begin
				top_val    = compare_a_reg;
				ovf_at_top = 1'b1;
			end
			default: top_val = `TCC_COUNT_MAX;
		endcase
	end

	// Capture input is off while the capture register is the ceiling
	assign cap_event = (timer_control_b[`TCC_CB_EDGE_BIT] ? cap_rise : cap_fall)
		& ~icr_is_top;

	// Next count: CPU write first, then tick step, else hold
	always_comb begin
		count_next = timer_count_value;
		dir_next   = dir_reg;
		ovf_hit    = 1'b0;
		if (cnt_wr) begin
			count_next = {hold_reg, cpu.wdata}; // see [R4] see [R5] see [R12]
		end else if (timer_tick) begin
			if (dual_slope) begin
				case (dir_reg) // see [R8]
					tcc_pkg::TCC_DIR_UP: begin
						if (timer_count_value >= top_val) begin
							dir_next   = tcc_pkg::TCC_DIR_DOWN;
							count_next = timer_count_value - `TCC_ONE;
						end else begin
							count_next = timer_count_value + `TCC_ONE;
						end
					end
					tcc_pkg::TCC_DIR_DOWN: begin
						if (timer_count_value == `TCC_COUNT_FLOOR) begin
							dir_next   = tcc_pkg::TCC_DIR_UP;
							count_next = timer_count_value + `TCC_ONE;
						end else begin
							count_next = timer_count_value - `TCC_ONE;
						end
					end
					default: dir_next = tcc_pkg::TCC_DIR_UP;
				endcase
				ovf_hit = timer_count_value == `TCC_COUNT_FLOOR; // see [R14]
			end else begin
				if (timer_count_value == top_val) begin
					count_next = `TCC_COUNT_FLOOR; // see [R9]
				end else begin
					count_next = timer_count_value + `TCC_ONE; // see [R8]
				end
				ovf_hit = timer_count_value == (ovf_at_top ? top_val : `TCC_COUNT_MAX);
			end
		end
	end

	// Counter and direction; reachable by CPU with or without ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_count_value <= `TCC_RST_WORD; // see [R25]
			dir_reg           <= tcc_pkg::TCC_DIR_UP;
		end else if (ce) begin
			timer_count_value <= count_next; // see [R11]
			dir_reg           <= dir_next;
		end
	end

	// Floor and ceiling indications track the stored count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_floor   <= 1'b1;
			count_ceiling <= 1'b0;
		end else if (ce) begin
			count_floor   <= count_next == `TCC_COUNT_FLOOR; // see [R9]
			count_ceiling <= count_next == top_val;
		end
	end

	// Shared holding byte for every 16-bit register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= `TCC_RST_BYTE; // see [R25]
		end else if (ce) begin
			if (cpu.wr && (cpu.sel == tcc_pkg::TCC_SEL_CNT_HI ||
				cpu.sel == tcc_pkg::TCC_SEL_CAP_HI ||
				cpu.sel == tcc_pkg::TCC_SEL_CMP_HI)) begin
				hold_reg <= cpu.wdata; // see [R2] see [R22]
			end else if (cpu.rd && cpu.sel == tcc_pkg::TCC_SEL_CNT_LO) begin
				hold_reg <= timer_count_value[15:8]; // see [R3]
			end else if (cpu.rd && cpu.sel == tcc_pkg::TCC_SEL_CAP_LO) begin
				hold_reg <= capture_value_reg[15:8]; // see [R19]
			end
		end
	end

	// Capture register: hardware copy, or CPU write in ceiling modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_value_reg <= `TCC_RST_WORD;
		end else if (ce) begin
			if (cap_event) begin
				capture_value_reg <= timer_count_value; // see [R15]
			end else if (cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_CAP_LO && icr_is_top) begin
				capture_value_reg <= {hold_reg, cpu.wdata}; // see [R20]
			end
		end
	end

	// Compare A register, one of the selectable ceilings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_a_reg <= `TCC_RST_WORD;
		end else if (ce && cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_CMP_LO) begin
			compare_a_reg <= {hold_reg, cpu.wdata};
		end
	end

	// Flags: hardware set wins over write-one clear and service ack
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_event_flag  <= 1'b0;
			count_overflow_flag <= 1'b0;
		end else if (ce) begin
			if (cap_event) begin
				capture_event_flag <= 1'b1; // see [R16]
			end else if (capture_irq_ack ||
				(flag_wr && cpu.wdata[`TCC_FLAG_CAP_BIT])) begin
				capture_event_flag <= 1'b0; // see [R17] see [R18]
			end
			if (ovf_hit) begin
				count_overflow_flag <= 1'b1; // see [R14]
			end else if (overflow_irq_ack ||
				(flag_wr && cpu.wdata[`TCC_FLAG_OVF_BIT])) begin
				count_overflow_flag <= 1'b0;
			end
		end
	end

	// Interrupt requests follow enabled flags one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_irq  <= 1'b0;
			overflow_irq <= 1'b0;
		end else if (ce) begin
			capture_irq  <= capture_event_flag & capture_irq_enable; // see [R17]
			overflow_irq <= count_overflow_flag & overflow_irq_enable;
		end
	end

	// Read data; high locations of counter and capture return the holding byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= `TCC_RST_BYTE;
		end else if (ce && cpu.rd) begin
			case (cpu.sel) // see [R1]
				tcc_pkg::TCC_SEL_CNT_LO: rdata <= timer_count_value[7:0];
				tcc_pkg::TCC_SEL_CNT_HI: rdata <= hold_reg; // see [R2]
				tcc_pkg::TCC_SEL_CAP_LO: rdata <= capture_value_reg[7:0];
				tcc_pkg::TCC_SEL_CAP_HI: rdata <= hold_reg;
				tcc_pkg::TCC_SEL_CMP_LO: rdata <= compare_a_reg[7:0];
				tcc_pkg::TCC_SEL_CMP_HI: rdata <= compare_a_reg[15:8];
				tcc_pkg::TCC_SEL_FLAGS: begin
					rdata <= `TCC_RST_BYTE;
					rdata[`TCC_FLAG_CAP_BIT] <= capture_event_flag;
					rdata[`TCC_FLAG_OVF_BIT] <= count_overflow_flag;
				end
				default: rdata <= `TCC_RST_BYTE;
			endcase
		end
	end

	// Checks
	sequence s_low_read;
		ce && cpu.rd && cpu.sel == tcc_pkg::TCC_SEL_CNT_LO && !cpu.wr;
	endsequence

	sequence s_high_read;
		ce && cpu.rd && cpu.sel == tcc_pkg::TCC_SEL_CNT_HI && !cpu.wr;
	endsequence

	property p_low_read_hold;
		@(posedge clk) disable iff (!rst_n)
		s_low_read |=> hold_reg == $past(timer_count_value[15:8]);
	endproperty
	a_low_read_hold: assert property (p_low_read_hold) // see [R3]
		else $error("low read did not load holding byte");

	property p_coherent_read;
		@(posedge clk) disable iff (!rst_n)
		(s_low_read ##1 (!cpu.rd && !cpu.wr) ##1 s_high_read) |=>
			rdata == $past(timer_count_value[15:8], 3);
	endproperty
	a_coherent_read: assert property (p_coherent_read) // see [R5]
		else $error("high read not coherent with low read");

	property p_low_write;
		@(posedge clk) disable iff (!rst_n)
		ce && cnt_wr |=> timer_count_value == {$past(hold_reg), $past(cpu.wdata)};
	endproperty
	a_low_write: assert property (p_low_write) // see [R12]
		else $error("counter write not taken");

	property p_high_write;
		@(posedge clk) disable iff (!rst_n)
		ce && cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_CNT_HI && !timer_tick |=>
			hold_reg == $past(cpu.wdata) && $stable(timer_count_value[15:8]);
	endproperty
	a_high_write: assert property (p_high_write) // see [R2]
		else $error("high write touched counter or missed holding byte");

	property p_stopped;
		@(posedge clk) disable iff (!rst_n)
		ce && tick_source_select == `TCC_CS_STOP && !cnt_wr |=> $stable(timer_count_value);
	endproperty
	a_stopped: assert property (p_stopped) // see [R10]
		else $error("counter moved with no tick source");

	property p_floor;
		@(posedge clk) disable iff (!rst_n)
		count_floor == (timer_count_value == `TCC_COUNT_FLOOR);
	endproperty
	a_floor: assert property (p_floor) // see [R9]
		else $error("floor indication wrong");

	property p_capture;
		@(posedge clk) disable iff (!rst_n)
		ce && cap_event |=> capture_value_reg == $past(timer_count_value) && capture_event_flag;
	endproperty
	a_capture: assert property (p_capture) // see [R16]
		else $error("capture copy or flag missing");

	property p_cap_clear;
		@(posedge clk) disable iff (!rst_n)
		ce && flag_wr && cpu.wdata[`TCC_FLAG_CAP_BIT] && !cap_event |=> !capture_event_flag;
	endproperty
	a_cap_clear: assert property (p_cap_clear) // see [R18]
		else $error("write one did not clear capture flag");

	property p_icr_guard;
		@(posedge clk) disable iff (!rst_n)
		ce && cpu.wr && cpu.sel == tcc_pkg::TCC_SEL_CAP_LO && !icr_is_top && !cap_event
			|=> $stable(capture_value_reg);
	endproperty
	a_icr_guard: assert property (p_icr_guard) // see [R20]
		else $error("capture register written outside ceiling mode");

	property p_normal_step;
		@(posedge clk) disable iff (!rst_n)
		ce && timer_tick && !cnt_wr && waveform_mode_field == 4'h0 |=>
			timer_count_value == $past(timer_count_value) + `TCC_ONE;
	endproperty
	a_normal_step: assert property (p_normal_step) // see [R8]
		else $error("normal mode step wrong");
endmodule

/* logic/tcc_edge_det.sv */
// Two-stage synchroniser with rising and falling edge pulses.
// Assumes an asynchronous input and a clock enable that freezes all state.
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_edge_det (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;

	// Synchroniser and previous sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
		end else if (ce) begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// Edge pulses, one enabled cycle wide
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise <= 1'b0;
			fall <= 1'b0;
		end else if (ce) begin
			rise <= sync2_reg & ~prev_reg;
			fall <= ~sync2_reg & prev_reg;
		end
	end
endmodule

/* pkg/tcc_params.svh */
// Constants of the 16-bit timer core: field positions, reset values and fixed ceilings.
// Assumes inclusion by bare name from every file that needs them.
// Function
// [R1] Counter appears as separate high and low byte locations.
// [R2] High-byte counter access reaches the shared holding byte only.
// [R3] Low-byte counter read loads counter upper byte into the holding byte.
// [R4] Low-byte counter write loads holding byte and written byte together.
// [R5] A full 16-bit transfer completes in the cycle of the low-byte access.
// [R6] Software masks interrupts over any two-access 16-bit sequence.
// [R7] Software may reuse one high-byte write for several low-byte writes.
// [R8] Counter clears, increments or decrements by one per tick, per mode.
// [R9] Floor shows zero count, ceiling shows top of sequence; clear zeroes all.
// [R10] Three-bit tick source field; zero stops the counter.
// [R11] Counter reads and writes work with or without ticks.
// [R12] A counter write beats a same-cycle clear or count step.
// [R13] Four-bit mode field is split over control registers A and B.
// [R14] Overflow flag sets at the mode's point and can request an interrupt.
// [R15] Qualifying capture edge copies the full counter into the capture register.
// [R16] Capture flag sets in the same cycle as the copy.
// [R17] Enabled capture flag requests an interrupt; servicing clears it.
// [R18] Writing one clears the capture flag; zero leaves it.
// [R19] Capture low read loads capture high byte into the holding byte.
// [R20] Capture register takes writes only in modes using it as ceiling.
// [R21] Software writes capture high byte before low byte.
// [R22] One holding byte serves every 16-bit register of the timer.
// [R23] Software writes high then low, and reads low then high.
// [R24] Fixed ceilings 0x00FF, 0x01FF, 0x03FF, else compare or capture register; modes 0x0 and 0xD use 0xFFFF.
// [R25] Reset zeroes counter, capture, holding byte, flag; no tick source.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

`define TCC_RST_WORD      16'h0000
`define TCC_RST_BYTE      8'h00
`define TCC_COUNT_MAX     16'hFFFF
`define TCC_COUNT_FLOOR   16'h0000
`define TCC_TOP_8BIT      16'h00FF
`define TCC_TOP_9BIT      16'h01FF
`define TCC_TOP_10BIT     16'h03FF
`define TCC_ONE           16'h0001

// Field positions in the control and flag bytes, and tick source codes
`define TCC_CA_WGM_LO     1
`define TCC_CA_WGM_HI     0
`define TCC_CB_WGM_HI     4
`define TCC_CB_WGM_LO     3
`define TCC_CB_CS_HI      2
`define TCC_CB_CS_LO      0
`define TCC_CB_EDGE_BIT   6
`define TCC_FLAG_OVF_BIT  0
`define TCC_FLAG_CAP_BIT  5
`define TCC_CS_STOP       3'h0
`define TCC_CS_EXT_FALL   3'h6
`define TCC_CS_EXT_RISE   3'h7

`endif

/* pkg/tcc_pkg.sv */
// Types shared by the timer core and its bench.
// Assumes the CPU issues at most one byte access per cycle.
package tcc_pkg;

	// Byte location addressed by a CPU access
	typedef enum logic [2:0] {
		TCC_SEL_CNT_LO = 3'h0,
		TCC_SEL_CNT_HI = 3'h1,
		TCC_SEL_CAP_LO = 3'h2,
		TCC_SEL_CAP_HI = 3'h3,
		TCC_SEL_CMP_LO = 3'h4,
		TCC_SEL_CMP_HI = 3'h5,
		TCC_SEL_FLAGS  = 3'h6,
		TCC_SEL_NONE   = 3'h7
	} tcc_sel_t;

	// Counting direction of dual-slope modes
	typedef enum logic {
		TCC_DIR_UP   = 1'b0,
		TCC_DIR_DOWN = 1'b1
	} tcc_dir_t;

	// One CPU byte access
	typedef struct packed {
		logic     rd;
		logic     wr;
		tcc_sel_t sel;
		logic [7:0] wdata;
	} tcc_cpu_t;

endpackage
